// *** cis_map.svh ***
// register offsets, field positions and reset values of the interrupt and status block
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH

`define CIS_ADDR_W        12
`define CIS_OFF_IRQ_EN    12'h004
`define CIS_OFF_IRQ_DIS   12'h008
`define CIS_OFF_IRQ_MASK  12'h00C
`define CIS_OFF_STATUS    12'h010

`define CIS_MASK_RESET    32'h0000_0000
`define CIS_STATUS_RESET  32'h0000_0000
`define CIS_MASK_VALID    32'h1FFF_00FF
`define CIS_STICKY_BITS   32'h1FC0_0000

`define CIS_MB_LSB        0
`define CIS_ERR_ACTIVE_BIT  16
`define CIS_WARN_BIT        17
`define CIS_ERR_PASSIVE_BIT 18
`define CIS_BUS_OFF_BIT     19
`define CIS_SLEEP_BIT       20
`define CIS_WAKEUP_BIT      21
`define CIS_ROLLOVER_BIT    22
`define CIS_STAMP_BIT       23
`define CIS_CRC_ERR_BIT     24
`define CIS_STUFF_ERR_BIT   25
`define CIS_ACK_ERR_BIT     26
`define CIS_FORM_ERR_BIT    27
`define CIS_BIT_ERR_BIT     28
`define CIS_RX_BUSY_BIT     29
`define CIS_TX_BUSY_BIT     30
`define CIS_OVL_BUSY_BIT    31

`define CIS_WARN_LIMIT    96
`define CIS_PASSIVE_LIMIT 128
`define CIS_BUSOFF_LIMIT  256

`endif

// *** cis_pkg.sv ***
// types shared by the interrupt and status block
package cis_pkg;
  typedef logic [31:0] cis_word_t;
  typedef enum logic [4:0] {
    CIS_SEL_NONE   = 5'b00001,
    CIS_SEL_EN     = 5'b00010,
    CIS_SEL_DIS    = 5'b00100,
    CIS_SEL_MASK   = 5'b01000,
    CIS_SEL_STATUS = 5'b10000
  } cis_sel_t;
endpackage : cis_pkg

// *** cis_err_conf.sv ***
// error confinement flags derived from the transmit and receive error counters
`timescale 1ns/100ps
`default_nettype none
`include "cis_map.svh"
module cis_err_conf #(
  parameter int TEC_W = 9,
  parameter int REC_W = 8
) (
  input  wire logic             pclk,          // peripheral clock
  input  wire logic             presetn,       // async reset, active low
  input  wire logic [TEC_W-1:0] tx_err_count,  // transmit error counter
  input  wire logic [REC_W-1:0] rx_err_count,  // receive error counter
  output logic                  error_active_flag,  // neither passive nor bus off
  output logic                  warn_flag,          // a counter above the warning limit
  output logic                  error_passive_flag, // a counter at passive limit or more
  output logic                  bus_off_flag        // transmit counter at bus-off limit or more
);
  logic tec_warn;
  logic rec_warn;
  logic tec_pass;
  logic rec_pass;
  logic bus_off_d;
  logic passive_d;

  assign tec_warn = 32'(tx_err_count) > `CIS_WARN_LIMIT;
  assign rec_warn = 32'(rx_err_count) > `CIS_WARN_LIMIT;
  assign tec_pass = 32'(tx_err_count) >= `CIS_PASSIVE_LIMIT;
  assign rec_pass = 32'(rx_err_count) >= `CIS_PASSIVE_LIMIT;
  assign bus_off_d = 32'(tx_err_count) >= `CIS_BUSOFF_LIMIT;  // see R12
  assign passive_d = tec_pass || rec_pass;  // see R9

  // flags follow the counters each cycle and never latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_active_flag  <= 1'b0;
      warn_flag          <= 1'b0;
      error_passive_flag <= 1'b0;
      bus_off_flag       <= 1'b0;
    end else begin
      error_active_flag  <= !passive_d && !bus_off_d;  // see R7 see R10
      warn_flag          <= tec_warn || rec_warn;  // see R8 see R10
      error_passive_flag <= passive_d;  // see R9 see R10
      bus_off_flag       <= bus_off_d;  // see R12
    end
  end
endmodule : cis_err_conf
`default_nettype wire

// *** cis_top.sv ***
// interrupt mask, status word and apb register slave of the can controller
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "cis_map.svh"

// Notes on behaviour
// R1: a one written to a bit of the enable register sets that mask bit, zeros leave it alone.
// R2: a one written to a bit of the disable register clears that mask bit, zeros do nothing, and it reads as zero.
// R3: enable, disable and mask share one layout of mailboxes, state flags and protocol errors.
// R4: the mask register reads one for every enabled source and zero for every disabled one.
// R5: the status word carries overload busy, transmitter busy and receiver busy at bits 31, 30 and 29.
// R6: a mailbox event bit is one while that mailbox reports ready or aborted.
// R7: error active is high exactly while the node is neither error passive nor bus off.
// R8: warning is high while either error counter is above 96.
// R9: error passive is high while either error counter is 128 or more.
// R10: error active, warning and error passive clear by themselves when their cause goes away.
// R11: every source except receiver, transmitter and overload busy (bits 29 to 31) can be enabled and disabled on its own.
// R12: bus off is high while the transmit error counter is 256 or more.
// R13: timer rollover, frame stamp and protocol error flags are sticky and clear when the status is read.
// R14: the interrupt is high while any status bit and its mask bit are both one.
// R15: all mask bits are cleared by reset.
module cis_top
  import cis_pkg::*;
#(
  parameter int NUM_MB = 8,
  parameter int TEC_W  = 9,
  parameter int REC_W  = 8
) (
  input  wire logic                        pclk,           // peripheral clock
  input  wire logic                        presetn,        // async reset, active low
  input  wire logic                        psel,           // apb select
  input  wire logic                        penable,        // apb access phase
  input  wire logic                        pwrite,         // apb direction
  input  wire logic [`CIS_ADDR_W-1:0]      paddr,          // apb byte address
  input  wire logic [31:0]                 pwdata,         // apb write data
  input  wire logic [3:0]                  pstrb,          // apb byte strobes
  output cis_pkg::cis_word_t               prdata,         // apb read data
  output logic                             pready,         // apb ready
  output logic                             pslverr,        // apb error, unmapped address
  input  wire logic [NUM_MB-1:0]           mailbox_ready,  // per mailbox ready
  input  wire logic [NUM_MB-1:0]           mailbox_aborted,// per mailbox aborted
  input  wire logic [TEC_W-1:0]            tx_err_count,   // transmit error counter
  input  wire logic [REC_W-1:0]            rx_err_count,   // receive error counter
  input  wire logic                        sleep_state,    // controller in low power
  input  wire logic                        wakeup_state,   // controller awake
  input  wire logic                        timer_rollover, // pulse, timer wrapped
  input  wire logic                        frame_stamp,    // pulse, frame start or end seen
  input  wire logic                        crc_error,      // pulse, crc error
  input  wire logic                        stuffing_error, // pulse, stuffing error
  input  wire logic                        ack_error,      // pulse, acknowledge error
  input  wire logic                        form_error,     // pulse, form error
  input  wire logic                        bit_error,      // pulse, bit error
  input  wire logic                        receiver_busy,  // receiving a frame
  input  wire logic                        transmitter_busy,// transmitting a frame
  input  wire logic                        overload_busy,  // sending an overload frame
  output logic                             irq             // level interrupt
);
  import cis_pkg::*;

  cis_word_t mask_q;
  cis_word_t mask_d;
  cis_word_t sticky_q;
  cis_word_t sticky_d;
  cis_word_t sticky_set;
  cis_word_t sticky_clr;
  cis_word_t snap_q;
  cis_word_t status_q;
  cis_word_t status_d;
  cis_word_t wr_data;
  cis_word_t rd_data;
  cis_sel_t  sel;
  logic      setup_ph;
  logic      access_ph;
  logic      wr_en;
  logic      wr_dis;
  logic      rd_status;
  logic      irq_q;
  logic      flag_active;
  logic      flag_warn;
  logic      flag_passive;
  logic      flag_bus_off;

  // address decode used by both apb phases
  function automatic cis_sel_t decode(input logic [`CIS_ADDR_W-1:0] a);
    cis_sel_t s;
    s = CIS_SEL_NONE;
    case (a)
      `CIS_OFF_IRQ_EN:   s = CIS_SEL_EN;
      `CIS_OFF_IRQ_DIS:  s = CIS_SEL_DIS;
      `CIS_OFF_IRQ_MASK: s = CIS_SEL_MASK;
      `CIS_OFF_STATUS:   s = CIS_SEL_STATUS;
      default:           s = CIS_SEL_NONE;
    endcase
    return s;
  endfunction : decode

  // expands byte strobes into a bit mask over the write data
  function automatic cis_word_t lane_mask(input logic [3:0] strb);
    cis_word_t m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : lane_mask

  cis_err_conf #(
    .TEC_W (TEC_W),
    .REC_W (REC_W)
  ) u_err_conf (
    .pclk               (pclk),
    .presetn            (presetn),
    .tx_err_count       (tx_err_count),
    .rx_err_count       (rx_err_count),
    .error_active_flag  (flag_active),
    .warn_flag          (flag_warn),
    .error_passive_flag (flag_passive),
    .bus_off_flag       (flag_bus_off)
  );

  // apb phases; the slave never inserts wait states
  assign sel       = decode(paddr);
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign pready    = 1'b1;
  assign pslverr   = access_ph && (sel == CIS_SEL_NONE);
  assign wr_data   = pwdata & lane_mask(pstrb) & `CIS_MASK_VALID;
  assign wr_en     = access_ph && pwrite && (sel == CIS_SEL_EN);
  assign wr_dis    = access_ph && pwrite && (sel == CIS_SEL_DIS);
  assign rd_status = access_ph && !pwrite && (sel == CIS_SEL_STATUS);

  // mask: write-one-to-set and write-one-to-clear, reserved bits stay zero
  always_comb begin
    mask_d = mask_q;
    if (wr_en) begin
      mask_d = mask_d | wr_data;  // see R1 see R11 see R3
    end
    if (wr_dis) begin
      mask_d = mask_d & ~wr_data;  // see R2 see R11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `CIS_MASK_RESET;  // see R15
    end else begin
      mask_q <= mask_d;
    end
  end

  // sticky event capture
  always_comb begin
    sticky_set                 = 32'h0000_0000;
    sticky_set[`CIS_ROLLOVER_BIT]  = timer_rollover;
    sticky_set[`CIS_STAMP_BIT]     = frame_stamp;
    sticky_set[`CIS_CRC_ERR_BIT]   = crc_error;
    sticky_set[`CIS_STUFF_ERR_BIT] = stuffing_error;
    sticky_set[`CIS_ACK_ERR_BIT]   = ack_error;
    sticky_set[`CIS_FORM_ERR_BIT]  = form_error;
    sticky_set[`CIS_BIT_ERR_BIT]   = bit_error;
  end

  // only bits that the read actually returned are cleared, so an event
  // landing between the setup and access edges is kept for the next read
  assign sticky_clr = rd_status ? (snap_q & `CIS_STICKY_BITS) : 32'h0000_0000;

  // a new event in the clearing cycle wins over the clear
  assign sticky_d = ((sticky_q & ~sticky_clr) | sticky_set) & `CIS_STICKY_BITS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_q <= `CIS_STATUS_RESET;
    end else begin
      sticky_q <= sticky_d;  // see R13
    end
  end

  // live status word
  always_comb begin
    status_d                     = sticky_q;
    status_d[`CIS_MB_LSB +: NUM_MB] = mailbox_ready | mailbox_aborted;  // see R6
    status_d[`CIS_ERR_ACTIVE_BIT]  = flag_active;  // see R7
    status_d[`CIS_WARN_BIT]        = flag_warn;  // see R8
    status_d[`CIS_ERR_PASSIVE_BIT] = flag_passive;  // see R9
    status_d[`CIS_BUS_OFF_BIT]     = flag_bus_off;  // see R12
    status_d[`CIS_SLEEP_BIT]       = sleep_state;
    status_d[`CIS_WAKEUP_BIT]      = wakeup_state;
    status_d[`CIS_RX_BUSY_BIT]     = receiver_busy;  // see R5
    status_d[`CIS_TX_BUSY_BIT]     = transmitter_busy;  // see R5
    status_d[`CIS_OVL_BUSY_BIT]    = overload_busy;  // see R5
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `CIS_STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // read mux, sampled at the setup edge
  always_comb begin
    case (sel)
      CIS_SEL_MASK:   rd_data = mask_q;  // see R4
      CIS_SEL_STATUS: rd_data = status_q;
      CIS_SEL_EN:     rd_data = 32'h0000_0000;
      CIS_SEL_DIS:    rd_data = 32'h0000_0000;  // see R2
      default:        rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= rd_data;
    end
  end

  // snapshot of sticky bits handed out by the pending status read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      snap_q <= (!pwrite && sel == CIS_SEL_STATUS) ? status_q : 32'h0000_0000;
    end
  end

  // interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);  // see R14
    end
  end

  assign irq = irq_q;
endmodule : cis_top
`default_nettype wire

// *** cis_top_properties.sv ***
// port assertions of the interrupt and status block
`timescale 1ns/100ps
`default_nettype none
`include "cis_map.svh"
module cis_props
  import cis_pkg::*;
#(
  parameter int NUM_MB = 8,
  parameter int TEC_W  = 9,
  parameter int REC_W  = 8
) (
  input wire logic              pclk,             // clock
  input wire logic              presetn,          // reset, active low
  input wire logic              psel,             // apb select
  input wire logic              penable,          // apb enable
  input wire logic              pwrite,           // apb direction
  input wire logic [11:0]       paddr,            // apb address
  input wire cis_pkg::cis_word_t prdata,          // apb read data
  input wire logic [NUM_MB-1:0] mailbox_ready,    // mailbox ready
  input wire logic [NUM_MB-1:0] mailbox_aborted,  // mailbox aborted
  input wire logic [TEC_W-1:0]  tx_err_count,     // tx counter
  input wire logic [REC_W-1:0]  rx_err_count,     // rx counter
  input wire logic              receiver_busy,    // rx busy
  input wire logic              transmitter_busy, // tx busy
  input wire logic              overload_busy     // overload busy
);
  logic [TEC_W-1:0] tec1_q, tec2_q, tec3_q;
  logic [REC_W-1:0] rec1_q, rec2_q, rec3_q;
  wire rd = psel & penable & ~pwrite;
  wire sr = rd & (paddr == `CIS_OFF_STATUS);
  wire wn = (tec3_q > 96) || (rec3_q > 96);
  wire ps = (tec3_q >= 128) || (rec3_q >= 128);
  wire bo = tec3_q >= 256;
  // counters as they stood when the status word now read was formed
  always_ff @(posedge pclk) begin
    {tec3_q, tec2_q, tec1_q} <= {tec2_q, tec1_q, tx_err_count};
    {rec3_q, rec2_q, rec1_q} <= {rec2_q, rec1_q, rx_err_count};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_MBOX: assert property (sr && $past(presetn, 2) |->
    prdata[7:0] == $past(mailbox_ready | mailbox_aborted, 2)) else $error("mailbox event bits wrong");
  AST_BUSY: assert property (sr && $past(presetn, 2) |->
    prdata[31:29] == $past({overload_busy, transmitter_busy, receiver_busy}, 2)) else $error("busy bits wrong");
  AST_ERR_ACTIVE: assert property (sr && $past(presetn, 3) |-> prdata[16] == !(ps || bo))
    else $error("error active flag wrong");
  AST_WARN: assert property (sr && $past(presetn, 3) |-> prdata[17] == wn)
    else $error("warning flag wrong");
  AST_ERR_PASSIVE: assert property (sr && $past(presetn, 3) |-> prdata[18] == ps)
    else $error("error passive flag wrong");
  AST_BUS_OFF: assert property (sr && $past(presetn, 3) |-> prdata[19] == bo)
    else $error("bus off flag wrong");
  AST_DIS: assert property (rd && paddr == `CIS_OFF_IRQ_DIS |-> prdata == '0)
    else $error("disable register not write only");
  AST_MASK: assert property (rd && paddr == `CIS_OFF_IRQ_MASK |-> (prdata & ~`CIS_MASK_VALID) == '0)
    else $error("reserved mask bits set");
endmodule : cis_props
`default_nettype wire

// *** cis_engine.sv ***
// model of protocol engine and mailbox status feeding the block
`timescale 1ns/100ps
`default_nettype none
module cis_engine (
  input wire logic  pclk,     // clock
  output var logic [7:0] mbr, // mailbox ready
  output var logic [7:0] mba, // mailbox aborted
  output var logic [8:0] tec, // tx error counter
  output var logic [7:0] rec, // rx error counter
  output var logic [4:0] lvl, // overload, tx, rx busy, wakeup, sleep
  output var logic [6:0] evt  // one-cycle events, status bits 22 up
);
  initial begin
    {mbr, mba, tec, rec, lvl, evt} = '0;
  end
  task automatic set_counts(input logic [8:0] t, input logic [7:0] r);
    @(posedge pclk);
    tec <= t;
    rec <= r;
  endtask : set_counts
  task automatic set_lvl(input logic [7:0] a, input logic [7:0] b, input logic [4:0] l);
    @(posedge pclk);
    mbr <= a;
    mba <= b;
    lvl <= l;
  endtask : set_lvl
  task automatic fire(input int b);
    @(posedge pclk);
    evt <= 7'(1 << b);
    @(posedge pclk);
    evt <= '0;
  endtask : fire
endmodule : cis_engine
`default_nettype wire

// *** cis_top_tb.sv ***
// self-checking bench of the interrupt and status block
`timescale 1ns/100ps
`default_nettype none
`include "cis_map.svh"
module cis_top_tb;
  import cis_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_seen;
  logic [11:0] paddr;
  cis_word_t   pwdata, prdata, got;
  logic [7:0]  mbr, mba, rec;
  logic [8:0]  tec;
  logic [4:0]  lvl;
  logic [6:0]  evt;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  cis_engine u_eng (.pclk, .mbr, .mba, .tec, .rec, .lvl, .evt);
  cis_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata,
    .pready, .pslverr, .mailbox_ready(mbr), .mailbox_aborted(mba), .tx_err_count(tec), .rx_err_count(rec),
    .sleep_state(lvl[0]), .wakeup_state(lvl[1]), .timer_rollover(evt[0]), .frame_stamp(evt[1]),
    .crc_error(evt[2]), .stuffing_error(evt[3]), .ack_error(evt[4]), .form_error(evt[5]), .bit_error(evt[6]),
    .receiver_busy(lvl[2]), .transmitter_busy(lvl[3]), .overload_busy(lvl[4]), .irq);
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results
  task automatic chk(input string nm, input cis_word_t s, input cis_word_t e);
    total_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input cis_word_t d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    got = prdata;
    err_seen = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic t_reset;
    apb(`CIS_OFF_IRQ_MASK, 0, 0);
    chk("mask", got, `CIS_MASK_RESET);
    apb(`CIS_OFF_STATUS, 0, 0);
    chk("status", got, 32'h0001_0000);
    chk("irq", 32'(irq), 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mask;
    for (int i = 0; i < 32; i++) begin
      apb(`CIS_OFF_IRQ_DIS, 1, 32'hFFFF_FFFF);
      apb(`CIS_OFF_IRQ_EN, 1, 32'h0000_0001 << i);
      apb(`CIS_OFF_IRQ_MASK, 0, 0);
      chk("mask bit", got, (32'h0000_0001 << i) & `CIS_MASK_VALID);
    end
    apb(`CIS_OFF_IRQ_EN, 1, 32'hFFFF_FFFF);
    apb(`CIS_OFF_IRQ_DIS, 1, 32'h0000_0001);
    apb(`CIS_OFF_IRQ_EN, 1, 0);
    apb(`CIS_OFF_IRQ_DIS, 1, 0);
    apb(`CIS_OFF_IRQ_MASK, 0, 0);
    chk("mask after zeros", got, 32'h1FFF_00FE);
    apb(`CIS_OFF_IRQ_DIS, 0, 0);
    chk("disable read", got, 32'h0000_0000);
    apb(12'h014, 0, 0);
    chk("unmapped", 32'(err_seen), 32'h0000_0001);
    $display("test mask done");
  endtask : t_mask
  task automatic t_counts;
    int tt[9] = '{0, 97, 96, 0, 127, 255, 256, 511, 0};
    int rr[9] = '{0, 0, 96, 128, 0, 0, 0, 255, 0};
    logic [3:0] ee[9] = '{4'h1, 4'h3, 4'h1, 4'h6, 4'h3, 4'h6, 4'hE, 4'hE, 4'h1};
    for (int i = 0; i < 9; i++) begin
      u_eng.set_counts(9'(tt[i]), 8'(rr[i]));
      repeat (3) @(posedge pclk);
      apb(`CIS_OFF_STATUS, 0, 0);
      chk("confinement", 32'(got[19:16]), 32'(ee[i]));
    end
    $display("test counters done");
  endtask : t_counts
  task automatic t_levels;
    u_eng.set_lvl(8'h05, 8'h30, 5'h1D);
    repeat (2) @(posedge pclk);
    apb(`CIS_OFF_STATUS, 0, 0);
    chk("levels", got, 32'hE011_0035);
    u_eng.set_lvl(8'h00, 8'h00, 5'h02);
    repeat (2) @(posedge pclk);
    apb(`CIS_OFF_STATUS, 0, 0);
    chk("levels gone", got, 32'h0021_0000);
    u_eng.set_lvl(8'h00, 8'h00, 5'h00);
    $display("test levels done");
  endtask : t_levels
  task automatic t_sticky;
    for (int i = 0; i < 7; i++) begin
      u_eng.fire(i);
      repeat (2) @(posedge pclk);
      apb(`CIS_OFF_STATUS, 0, 0);
      chk("sticky held", got, 32'h0001_0000 | (32'h0000_0001 << (22 + i)));
      apb(`CIS_OFF_STATUS, 0, 0);
      chk("sticky cleared", got, 32'h0001_0000);
    end
    $display("test sticky done");
  endtask : t_sticky
  task automatic t_irq;
    cis_word_t wv[6] = '{32'hFFFF_FFFF, 0, 32'h0100_0000, 0, 32'h0001_0000, 32'h0001_0000};
    logic [11:0] av[6] = '{`CIS_OFF_IRQ_DIS, 0, `CIS_OFF_IRQ_EN, `CIS_OFF_STATUS, `CIS_OFF_IRQ_EN,
                           `CIS_OFF_IRQ_DIS};
    logic ev[6] = '{0, 0, 1, 0, 1, 0};
    for (int i = 0; i < 6; i++) begin
      if (i == 1)
        u_eng.fire(2);
      else
        apb(av[i], av[i] != `CIS_OFF_STATUS, wv[i]);
      repeat (3) @(posedge pclk);
      chk("irq", 32'(irq), 32'(ev[i]));
    end
    $display("test irq done");
  endtask : t_irq
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_mismatch++;
      results;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_mask;
    t_counts;
    t_levels;
    t_sticky;
    t_irq;
    results;
  end
endmodule : cis_top_tb
bind cis_top cis_props #(.NUM_MB(NUM_MB), .TEC_W(TEC_W), .REC_W(REC_W)) u_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .mailbox_ready, .mailbox_aborted, .tx_err_count, .rx_err_count,
  .receiver_busy, .transmitter_busy, .overload_busy);
`default_nettype wire
